// File: common/cpu_ops_defines.svh
/*
  Constants of the return/reset instruction executor: register offsets, field positions,
  reset values and instruction selector codes.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
`ifndef CPU_OPS_DEFINES_SVH
`define CPU_OPS_DEFINES_SVH

// register byte offsets
`define ADDR_CMD        8'h00
`define ADDR_WORK       8'h04
`define ADDR_OPTION     8'h08
`define ADDR_PWRSTAT    8'h0C
`define ADDR_IRQCTL     8'h10
`define ADDR_PC         8'h14
`define ADDR_STACK      8'h18
`define ADDR_STATUS     8'h1C
`define ADDR_CORE       8'h20

// command word fields
`define CMD_OP_MSB      2
`define CMD_OP_LSB      0
`define CMD_LIT_MSB     15
`define CMD_LIT_LSB     8

// instruction selector codes
`define OP_NOP          3'h0
`define OP_OPTION       3'h1
`define OP_SWRESET      3'h2
`define OP_RET_IRQ      3'h3
`define OP_RET_LIT      3'h4

// field positions and widths
`define IRQ_EN_BIT      7
`define RSTFLAG_BIT     2
`define PC_W            15
`define STATUS_W        3
`define PTR_W           4
`define STACK_DEPTH     16
`define CORE_BUSY_BIT   0
`define CORE_PTR_LSB    4

// reset values and pc step
`define WORK_RST        8'h00
`define OPTION_RST      8'hFF
`define IRQCTL_RST      8'h00
`define PC_RST          15'h0000
`define STATUS_RST      3'h0
`define RSTFLAG_RST     1'h1
`define PC_STEP         15'h0001

`endif

// File: common/cpu_ops_pkg.sv
/*
  Types of the return/reset instruction executor.
  Takes no constants from cpu_ops_defines.svh; state encodings are written here.
*/
package cpu_ops_pkg;

  // one-hot execution states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_EXEC   = 3'h2,
    ST_SECOND = 3'h4
  } exec_state_e;

  typedef logic [7:0] byte_t;

endpackage

// File: rtl/return_stack.sv
/*
  Hardware return stack, circular, fixed depth; a pointer that wraps like the core's own.
  Assumes the owner never pushes and pops in one cycle.
*/
`timescale 1ns/1ps
`include "cpu_ops_defines.svh"

module return_stack (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  push,
  input  wire logic                  pop,
  input  wire logic [`PC_W-1:0]      push_data,
  output logic      [`PC_W-1:0]      stack_top,
  output logic      [`PTR_W-1:0]     ptr
);

  logic [`PC_W-1:0]  mem [`STACK_DEPTH];
  logic [`PTR_W-1:0] ptr_r;
  logic [`PTR_W-1:0] ptr_nxt;
  logic [`PTR_W-1:0] top_idx;

  // pointer names the next free slot, top is the slot below
  assign top_idx   = ptr_r - `PTR_W'(1);
  assign stack_top = mem[top_idx];
  assign ptr       = ptr_r;
  assign ptr_nxt   = push ? ptr_r + `PTR_W'(1) : (pop ? top_idx : ptr_r);

  // pointer update
  always_ff @(posedge clock)
  begin
    if (reset)
      ptr_r <= '0;
    else
      ptr_r <= ptr_nxt;
  end

  // storage has no reset
  always_ff @(posedge clock)
  begin
    if (push)
      mem[ptr_r] <= push_data;
  end

endmodule

// File: rtl/cpu_return_reset_ops.sv
/*
  Executor of the no-operation, load-option, software reset, return-from-interrupt and
  return-with-literal instructions, with its core state reachable as an AHB-Lite slave.
  Assumes a single AHB-Lite master, word transfers only, hready fed back from hreadyout.
*/
`timescale 1ns/1ps
`include "cpu_ops_defines.svh"

module cpu_return_reset_ops (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  output logic              device_reset_req
);

  // address hit on a mapped word
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  // bus slave state
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [31:0] addr_r;
  logic [31:0] hrdata_r;
  logic        hready_r;
  logic        hresp_r;
  logic        accept;

  // core state
  cpu_ops_pkg::exec_state_e state_r;
  cpu_ops_pkg::exec_state_e state_nxt;
  logic [2:0]           op_r;
  cpu_ops_pkg::byte_t   lit_r;
  cpu_ops_pkg::byte_t   work_r;
  cpu_ops_pkg::byte_t   work_nxt;
  cpu_ops_pkg::byte_t   option_r;
  cpu_ops_pkg::byte_t   option_nxt;
  cpu_ops_pkg::byte_t   irqctl_r;
  cpu_ops_pkg::byte_t   irqctl_nxt;
  logic [`PC_W-1:0]     pc_r;
  logic [`PC_W-1:0]     pc_nxt;
  logic [`STATUS_W-1:0] status_r;
  logic [`STATUS_W-1:0] status_nxt;
  logic                 rstflag_r;
  logic                 rstflag_nxt;
  logic                 swrst_r;
  logic                 core_rst;

  // stack wiring
  logic [`PC_W-1:0]  stack_top;
  logic [`PTR_W-1:0] stack_ptr;
  logic              pop;
  logic              push;

  // decoded write strobes, valid in the write data phase
  logic wr_cmd;
  logic wr_work;
  logic wr_option;
  logic wr_pwrstat;
  logic wr_irqctl;
  logic wr_pc;
  logic wr_stack;
  logic wr_status;

  // decoded current instruction
  logic exec;
  logic is_option;
  logic is_swreset;
  logic is_ret_irq;
  logic is_ret_lit;
  logic two_cycle;
  logic busy;
  logic [31:0] rd_mux;

  // read words of each register, zero-extended
  logic [31:0] rd_cmd_w;
  logic [31:0] rd_work_w;
  logic [31:0] rd_option_w;
  logic [31:0] rd_pwrstat_w;
  logic [31:0] rd_irqctl_w;
  logic [31:0] rd_pc_w;
  logic [31:0] rd_stack_w;
  logic [31:0] rd_status_w;
  logic [31:0] rd_core_w;

  // address phase taken when selected, non-idle and bus ready
  assign accept = hsel && htrans[1] && hready;

  // write decode
  assign wr_cmd    = wr_pend_r && hit(addr_r, `ADDR_CMD);
  assign wr_work   = wr_pend_r && hit(addr_r, `ADDR_WORK);
  assign wr_option = wr_pend_r && hit(addr_r, `ADDR_OPTION);
  assign wr_pwrstat = wr_pend_r && hit(addr_r, `ADDR_PWRSTAT);
  assign wr_irqctl = wr_pend_r && hit(addr_r, `ADDR_IRQCTL);
  assign wr_pc     = wr_pend_r && hit(addr_r, `ADDR_PC);
  assign wr_stack  = wr_pend_r && hit(addr_r, `ADDR_STACK);
  assign wr_status = wr_pend_r && hit(addr_r, `ADDR_STATUS);

  // instruction decode; unknown selector codes behave as no-operation
  assign exec       = (state_r == cpu_ops_pkg::ST_EXEC);
  assign is_option  = exec && (op_r == `OP_OPTION);
  assign is_swreset = exec && (op_r == `OP_SWRESET);
  assign is_ret_irq = exec && (op_r == `OP_RET_IRQ);
  assign is_ret_lit = exec && (op_r == `OP_RET_LIT);
  assign two_cycle  = is_ret_irq || is_ret_lit;
  assign busy       = (state_r != cpu_ops_pkg::ST_IDLE);

  // a software reset acts on all core state except the reset flag exactly like the reset pin
  // core reset, from pin or software reset
  assign core_rst = reset || swrst_r;

  // both returns take the return address off the stack
  // pop on return
  assign pop  = is_ret_irq || is_ret_lit;
  assign push = wr_stack && !pop;

  // program counter: returns load top of stack, others step by one
  // only the pc advances
  assign pc_nxt = pop  ? stack_top :
                  exec ? pc_r + `PC_STEP :
                  wr_pc ? hwdata[`PC_W-1:0] : pc_r;

  // working register takes the literal
  // literal into working
  assign work_nxt = is_ret_lit ? lit_r :
                    wr_work  ? hwdata[7:0] : work_r;

  // option register loaded from working register
  // working to option
  assign option_nxt = is_option ? work_r :
                      wr_option ? hwdata[7:0] : option_r;

  // global interrupt enable forced on by interrupt return
  // set enable bit
  assign irqctl_nxt = is_ret_irq ? (irqctl_r | (8'h01 << `IRQ_EN_BIT)) :
                      wr_irqctl ? hwdata[7:0] : irqctl_r;

  // arithmetic flags follow software writes only
  // flags untouched
  assign status_nxt = wr_status ? hwdata[`STATUS_W-1:0] : status_r;

  // reset-instruction flag drops on software reset, wins over a write
  // clear reset flag
  assign rstflag_nxt = is_swreset ? 1'b0 :
                       wr_pwrstat ? hwdata[`RSTFLAG_BIT] : rstflag_r;

  // sequencing: two-cycle ops spend a second cycle while the fetch refills
  // two-cycle returns
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      cpu_ops_pkg::ST_IDLE:
        if (wr_cmd)
          state_nxt = cpu_ops_pkg::ST_EXEC;
      cpu_ops_pkg::ST_EXEC:
        state_nxt = two_cycle ? cpu_ops_pkg::ST_SECOND : cpu_ops_pkg::ST_IDLE;
      cpu_ops_pkg::ST_SECOND:
        state_nxt = cpu_ops_pkg::ST_IDLE;
      default:
        state_nxt = cpu_ops_pkg::ST_IDLE;
    endcase
  end

  // read words, narrow fields in the low bits
  assign rd_cmd_w     = {16'h0000, lit_r, 5'h00, op_r};
  assign rd_work_w    = {24'h000000, work_r};
  assign rd_option_w  = {24'h000000, option_r};
  assign rd_pwrstat_w = {29'h00000000, rstflag_r, 2'h0};
  assign rd_irqctl_w  = {24'h000000, irqctl_r};
  assign rd_pc_w      = {17'h00000, pc_r};
  assign rd_stack_w   = {17'h00000, stack_top};
  assign rd_status_w  = {29'h00000000, status_r};
  assign rd_core_w    = {24'h000000, stack_ptr, 3'h0, busy};

  // read data selection; unmapped words read zero
  assign rd_mux =
    hit(addr_r, `ADDR_CMD)     ? rd_cmd_w :
    hit(addr_r, `ADDR_WORK)    ? rd_work_w :
    hit(addr_r, `ADDR_OPTION)  ? rd_option_w :
    hit(addr_r, `ADDR_PWRSTAT) ? rd_pwrstat_w :
    hit(addr_r, `ADDR_IRQCTL)  ? rd_irqctl_w :
    hit(addr_r, `ADDR_PC)      ? rd_pc_w :
    hit(addr_r, `ADDR_STACK)   ? rd_stack_w :
    hit(addr_r, `ADDR_STATUS)  ? rd_status_w :
    hit(addr_r, `ADDR_CORE)    ? rd_core_w : 32'h00000000;

  // hardware return stack
  return_stack u_stack (
    .clock     (clock),
    .reset     (core_rst),
    .push      (push),
    .pop       (pop),
    .push_data (hwdata[`PC_W-1:0]),
    .stack_top (stack_top),
    .ptr       (stack_ptr)
  );

  // bus address phase capture; reads add one wait state
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 32'h00000000;
      hready_r  <= 1'b1;
    end
    else
    begin
      wr_pend_r <= accept && hwrite;
      rd_pend_r <= accept && !hwrite;
      if (accept)
        addr_r <= haddr;
      hready_r <= !(accept && !hwrite);
    end
  end

  // read data loaded in the wait state
  always_ff @(posedge clock)
  begin
    if (reset)
      hrdata_r <= 32'h00000000;
    else if (rd_pend_r)
      hrdata_r <= rd_mux;
  end

  // command capture, refused while busy
  always_ff @(posedge clock)
  begin
    if (core_rst)
    begin
      op_r  <= `OP_NOP;
      lit_r <= 8'h00;
    end
    else if (wr_cmd && !busy)
    begin
      op_r  <= hwdata[`CMD_OP_MSB:`CMD_OP_LSB];
      lit_r <= hwdata[`CMD_LIT_MSB:`CMD_LIT_LSB];
    end
  end

  // core registers and sequencer
  always_ff @(posedge clock)
  begin
    if (core_rst)
    begin
      state_r  <= cpu_ops_pkg::ST_IDLE;
      work_r   <= `WORK_RST;
      option_r <= `OPTION_RST;
      irqctl_r <= `IRQCTL_RST;
      pc_r     <= `PC_RST;
      status_r <= `STATUS_RST;
    end
    else
    begin
      state_r  <= state_nxt;
      work_r   <= work_nxt;
      option_r <= option_nxt;
      irqctl_r <= irqctl_nxt;
      pc_r     <= pc_nxt;
      status_r <= status_nxt;
    end
  end

  // reset flag survives the software reset it records
  always_ff @(posedge clock)
  begin
    if (reset)
      rstflag_r <= `RSTFLAG_RST;
    else
      rstflag_r <= rstflag_nxt;
  end

  // one-cycle device reset request
  // reset pulse
  always_ff @(posedge clock)
  begin
    if (reset)
      swrst_r <= 1'b0;
    else
      swrst_r <= is_swreset;
  end

  // response register; this slave never signals an error
  always_ff @(posedge clock)
  begin
    if (reset)
      hresp_r <= 1'b0;
    else
      hresp_r <= 1'b0;
  end

  // bus outputs straight from flops; response always okay
  assign hrdata           = hrdata_r;
  assign hreadyout        = hready_r;
  assign hresp            = hresp_r;
  assign device_reset_req = swrst_r;

endmodule

// File: testbench/cpu_ops_sva.sv
/*
  Port-level checker for the return/reset op executor.
  Assumes one AHB-Lite master with hready fed from hreadyout.
*/
`timescale 1ns/1ps

module cpu_ops_sva (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        device_reset_req
);
  logic cmd_dph_r;
  // address phase taken, and a command write carrying the reset op
  wire  taken = hsel & htrans[1] & hready;
  wire  sw_op = cmd_dph_r & (hwdata[2:0] == 3'h2);

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // marks the data phase of a command write
  always_ff @(posedge clock)
    if (reset)
      cmd_dph_r <= 1'b0;
    else if (hready)
      cmd_dph_r <= taken & hwrite & (haddr == 32'h0);

  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
    else $error("write inserted wait");
  chk_swreset_pulse: assert property (sw_op |-> ##2 device_reset_req)
    else $error("no reset request after reset op");
  chk_pulse_single: assert property (device_reset_req |=> !device_reset_req)
    else $error("reset request longer than one cycle");
  chk_no_spurious: assert property (device_reset_req |-> $past(sw_op, 2))
    else $error("reset request without reset op");
  chk_other_quiet: assert property (cmd_dph_r && hwdata[2:0] != 3'h2 |-> ##1 !device_reset_req [*2])
    else $error("reset request after other op");
  chk_reset_idle: assert property ($fell(reset) |-> hreadyout && !device_reset_req && hrdata == 32'h0)
    else $error("outputs not idle after reset");

  cov_read: cover property (taken && !hwrite);
  cov_cmd: cover property (cmd_dph_r);
  cov_swreset: cover property (device_reset_req);
endmodule

// File: testbench/tb_top.sv
/*
  Self-checking bench of the return/reset op executor.
  Assumes the executor is reached only through its AHB-Lite slave port.
*/
`timescale 1ns/1ps
`include "cpu_ops_defines.svh"

module tb_top;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         device_reset_req;
  int          err_count = 0;
  int          num_checks = 0;

  cpu_return_reset_ops uut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .device_reset_req(device_reset_req));

  // 50 ns clock
  initial
  begin
    forever #25 clock = ~clock;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // waits for hready sampled high, bounded
  task automatic hwait;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_count++;
        conclude();
      end
      @(posedge clock);
    end
  endtask

  // one single word transfer, started at the edge the caller stands on; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(nm, e, q);
  endtask

  // issues an op, then polls busy until clear
  task automatic cmd(input logic [2:0] op, input logic [7:0] lit);
    int n;
    bus(1'b1, `ADDR_CMD, {16'h0, lit, 5'h0, op});
    n = 0;
    bus(1'b0, `ADDR_CORE, 32'h0);
    while (q[`CORE_BUSY_BIT] !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        err_count++;
        conclude();
      end
      bus(1'b0, `ADDR_CORE, 32'h0);
    end
  endtask

  task automatic t_reset;
    chk("work", `ADDR_WORK, {24'h0, `WORK_RST});
    chk("option", `ADDR_OPTION, {24'h0, `OPTION_RST});
    chk("irqctl", `ADDR_IRQCTL, {24'h0, `IRQCTL_RST});
    chk("pc", `ADDR_PC, {17'h0, `PC_RST});
    chk("pwrstat", `ADDR_PWRSTAT, 32'h4);
    chk("core", `ADDR_CORE, 32'h0);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    chk("unmapped", 8'h40, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_nop;
    logic [2:0] ops [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
    bus(1'b1, `ADDR_PC, 32'h5);
    bus(1'b1, `ADDR_STATUS, 32'h5);
    foreach (ops[i]) cmd(ops[i], 8'hAA);
    chk("pc", `ADDR_PC, 32'h9);
    chk("status", `ADDR_STATUS, 32'h5);
    chk("work", `ADDR_WORK, 32'h0);
    chk("option", `ADDR_OPTION, 32'hFF);
    chk("irqctl", `ADDR_IRQCTL, 32'h0);
    $display("test nop done");
  endtask

  task automatic t_option;
    bus(1'b1, `ADDR_WORK, 32'h4F);
    cmd(`OP_OPTION, 8'h00);
    chk("option", `ADDR_OPTION, 32'h4F);
    chk("work", `ADDR_WORK, 32'h4F);
    chk("pc", `ADDR_PC, 32'hA);
    $display("test option done");
  endtask

  task automatic t_returns;
    bus(1'b1, `ADDR_STACK, 32'h1234);
    bus(1'b1, `ADDR_STACK, 32'h0ABC);
    bus(1'b1, `ADDR_IRQCTL, 32'h05);
    cmd(`OP_RET_IRQ, 8'h00);
    chk("pc", `ADDR_PC, 32'h0ABC);
    chk("irqctl", `ADDR_IRQCTL, 32'h85);
    chk("top", `ADDR_STACK, 32'h1234);
    cmd(`OP_RET_LIT, 8'hFF);
    chk("work", `ADDR_WORK, 32'hFF);
    chk("pc", `ADDR_PC, 32'h1234);
    chk("core", `ADDR_CORE, 32'h0);
    chk("status", `ADDR_STATUS, 32'h5);
    $display("test returns done");
  endtask

  // a command write right behind a two-cycle op lands while it still runs and is refused
  task automatic t_timing;
    bus(1'b1, `ADDR_WORK, 32'h3C);
    bus(1'b1, `ADDR_STACK, 32'h77);
    bus(1'b1, `ADDR_STACK, 32'h66);
    bus(1'b1, `ADDR_CMD, {29'h0, `OP_RET_IRQ});
    bus(1'b1, `ADDR_CMD, {29'h0, `OP_OPTION});
    chk("option", `ADDR_OPTION, 32'h4F);
    chk("pc", `ADDR_PC, 32'h66);
    bus(1'b1, `ADDR_CMD, {16'h0, 8'h5A, 5'h0, `OP_RET_LIT});
    bus(1'b1, `ADDR_CMD, {29'h0, `OP_OPTION});
    chk("option", `ADDR_OPTION, 32'h4F);
    chk("work", `ADDR_WORK, 32'h5A);
    chk("pc", `ADDR_PC, 32'h77);
    bus(1'b1, `ADDR_CMD, {29'h0, `OP_NOP});
    bus(1'b1, `ADDR_CMD, {29'h0, `OP_OPTION});
    chk("option", `ADDR_OPTION, 32'h5A);
    $display("test timing done");
  endtask

  task automatic t_swreset;
    bus(1'b1, `ADDR_PWRSTAT, 32'h4);
    bus(1'b1, `ADDR_STACK, 32'h11);
    cmd(`OP_SWRESET, 8'h00);
    chk("pwrstat", `ADDR_PWRSTAT, 32'h0);
    chk("core", `ADDR_CORE, 32'h0);
    chk("status", `ADDR_STATUS, 32'h0);
    chk("work", `ADDR_WORK, 32'h0);
    chk("option", `ADDR_OPTION, 32'hFF);
    chk("pc", `ADDR_PC, 32'h0);
    chk("irqctl", `ADDR_IRQCTL, 32'h0);
    $display("test swreset done");
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_nop();
    t_option();
    t_returns();
    t_timing();
    t_swreset();
    conclude();
  end
endmodule

bind cpu_return_reset_ops cpu_ops_sva chk_i (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .device_reset_req(device_reset_req));
